// file: logic/pbm_ctrl.sv
// module: loop bandwidth, multiplier and range control with an AXI4-Lite register port
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module pbm_ctrl (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pbm_pkg::PBM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [pbm_pkg::PBM_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic loop_lock_in,
   input wire logic loop_track_in,
   input wire logic wait_mode,
   input wire logic stop_mode,
   input wire logic osc_run_in_stop,
   input wire logic break_active,
   input wire logic break_clear_enable,
   output logic osc_enable,
   output logic loop_enable,
   output logic vco_select,
   output logic crystal_clock_en,
   output logic base_clock_out_en,
   output logic clockgen_irq,
   output logic force_track,
   output logic bandwidth_auto,
   output logic [11:0] feedback_divider,
   output logic [7:0] vco_range_field,
   output logic [1:0] vco_power_range
);
   import pbm_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic irq_en_r; // loop_change_irq_enable
   logic flag_r; // loop_change_flag
   logic pwr_on_r; // loop_power_on
   logic bcs_r; // base_clock_source
   logic [1:0] vpr_r; // power-of-two range
   logic auto_r; // automatic bandwidth control
   logic acq_man_r; // hidden manual acquire/track value
   logic lock_prev_r; // lock level last cycle
   logic [11:0] mul_r; // feedback_divider_high and _low
   logic [7:0] vrs_r; // vco_range_field
   logic aw_full_r; // write address held
   logic w_full_r; // write data held
   logic [PBM_ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic w_lane0_r; // low byte lane enabled
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // ---------------------------------------------------------------
   // decode and derived terms
   // ---------------------------------------------------------------
   logic wr_fire; // write performed this cycle
   logic rd_fire; // read address taken this cycle
   logic wr_en; // write of low byte lane
   logic vrs_zero; // range programmed as zero
   logic stop_all; // stop with oscillator stopped
   logic lock_ind; // lock indicator as software sees it
   logic lock_toggle; // lock level changed in auto mode
   logic flag_clr; // read clears the flag
   logic acq_read; // acquire/track as read
   logic [7:0] loop_control_reg_val;
   logic [7:0] bandwidth_control_reg_val;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic wr_hit;

   assign wr_fire = clk_en && aw_full_r && w_full_r && !bvalid_r;
   assign rd_fire = clk_en && s_axi_arvalid && !rvalid_r;
   assign wr_en = wr_fire && w_lane0_r;
   assign vrs_zero = (vrs_r == 8'h00);
   assign stop_all = stop_mode && !osc_run_in_stop;
   assign lock_ind = auto_r && loop_lock_in;
   assign lock_toggle = auto_r && (loop_lock_in != lock_prev_r);
   // a read during break only clears when break clearing is allowed
   assign flag_clr = rd_fire && (s_axi_araddr == PBM_OFS_LOOP_CTRL)
                     && (!break_active || break_clear_enable);
   assign acq_read = auto_r ? loop_track_in : acq_man_r;

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   // hold address and data separately so they may come in either order
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_full_r <= 1'b0;
         end
      end
   end

   // data and lane enable of the pending write
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         w_full_r <= 1'b0;
         w_data_r <= '0;
         w_lane0_r <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_lane0_r <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_full_r <= 1'b0;
         end
      end
   end

   assign s_axi_awready = clk_en && !aw_full_r;
   assign s_axi_wready = clk_en && !w_full_r;

   // address decode of the pending write
   always_comb begin
      unique case (aw_addr_r)
         PBM_OFS_LOOP_CTRL, PBM_OFS_BW_CTRL, PBM_OFS_MUL_HIGH,
         PBM_OFS_MUL_LOW, PBM_OFS_VCO_RANGE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= PBM_RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? PBM_RESP_OKAY : PBM_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   // loop control view: unused bits read zero
   always_comb begin
      loop_control_reg_val = 8'h00;
      loop_control_reg_val[PBM_BIT_IRQ_EN] = irq_en_r;
      loop_control_reg_val[PBM_BIT_FLAG] = flag_r && auto_r;
      loop_control_reg_val[PBM_BIT_PWR_ON] = pwr_on_r;
      loop_control_reg_val[PBM_BIT_BCS] = bcs_r;
      loop_control_reg_val[PBM_BIT_VPR_HI:0] = vpr_r;
      bandwidth_control_reg_val = 8'h00;
      bandwidth_control_reg_val[PBM_BIT_AUTO] = auto_r;
      bandwidth_control_reg_val[PBM_BIT_LOCK] = lock_ind;
      bandwidth_control_reg_val[PBM_BIT_ACQ] = acq_read;
   end

   // read mux over the map
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         PBM_OFS_LOOP_CTRL: rd_byte = loop_control_reg_val;
         PBM_OFS_BW_CTRL: rd_byte = bandwidth_control_reg_val;
         PBM_OFS_MUL_HIGH: rd_byte = {4'h0, mul_r[11:8]};
         PBM_OFS_MUL_LOW: rd_byte = mul_r[7:0];
         PBM_OFS_VCO_RANGE: rd_byte = vrs_r;
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read data registered one cycle after the address is taken
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= PBM_RESP_OKAY;
      end else if (clk_en) begin
         if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= rd_hit ? PBM_RESP_OKAY : PBM_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_arready = clk_en && !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ---------------------------------------------------------------
   // loop control register
   // ---------------------------------------------------------------
   // power-on and source bits guard each other against an unclocked base
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pwr_on_r <= PBM_RST_PWR_ON;
         bcs_r <= 1'b0;
         vpr_r <= 2'h0;
         irq_en_r <= 1'b0;
      end else if (clk_en) begin
         if (wr_en && aw_addr_r == PBM_OFS_LOOP_CTRL) begin
            pwr_on_r <= w_data_r[PBM_BIT_PWR_ON] || bcs_r;
            // source only set with loop already on and range nonzero
            bcs_r <= w_data_r[PBM_BIT_BCS] && pwr_on_r && !vrs_zero;
            if (!pwr_on_r) begin
               vpr_r <= w_data_r[PBM_BIT_VPR_HI:0];
            end
            irq_en_r <= w_data_r[PBM_BIT_IRQ_EN] && auto_r;
         end else if (vrs_zero) begin
            bcs_r <= 1'b0;
         end
         if (!auto_r) begin
            irq_en_r <= 1'b0;
         end
      end
   end

   // change flag: a lock change in the clear cycle wins over the clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flag_r <= 1'b0;
         lock_prev_r <= 1'b0;
      end else if (clk_en) begin
         lock_prev_r <= loop_lock_in;
         if (!auto_r) begin
            flag_r <= 1'b0;
         end else if (lock_toggle) begin
            flag_r <= 1'b1;
         end else if (flag_clr) begin
            flag_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // bandwidth control register
   // ---------------------------------------------------------------
   // manual value only moves in manual mode, so it survives auto mode
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         auto_r <= 1'b0;
         acq_man_r <= PBM_RST_ACQ;
      end else if (clk_en) begin
         if (wr_en && aw_addr_r == PBM_OFS_BW_CTRL) begin
            auto_r <= w_data_r[PBM_BIT_AUTO];
            if (!auto_r) begin
               acq_man_r <= w_data_r[PBM_BIT_ACQ];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // multiplier and range registers
   // ---------------------------------------------------------------
   // both locked while the loop is on
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mul_r <= PBM_RST_MUL;
         vrs_r <= PBM_RST_VRS;
      end else if (clk_en) begin
         if (wr_en && !pwr_on_r) begin
            if (aw_addr_r == PBM_OFS_MUL_HIGH) begin
               mul_r[11:8] <= w_data_r[3:0];
            end
            if (aw_addr_r == PBM_OFS_MUL_LOW) begin
               mul_r[7:0] <= w_data_r[7:0];
            end
            if (aw_addr_r == PBM_OFS_VCO_RANGE) begin
               vrs_r <= w_data_r[7:0];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs to the analog loop and clock tree
   // ---------------------------------------------------------------
   // wait state has no term here: the block runs on unchanged
   assign feedback_divider = (mul_r == 12'h000) ? PBM_MUL_ONE : mul_r;
   assign vco_range_field = vrs_r;
   assign vco_power_range = vpr_r;
   assign loop_enable = pwr_on_r && !vrs_zero && !stop_mode;
   assign osc_enable = !stop_all;
   assign crystal_clock_en = !stop_all;
   assign base_clock_out_en = !stop_all;
   assign vco_select = bcs_r;
   assign force_track = acq_man_r;
   assign bandwidth_auto = auto_r;
   assign clockgen_irq = flag_r && irq_en_r && auto_r && !stop_all;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   chk_irq_follows_flag: assert property (
      clk_en && clockgen_irq && !flag_clr |=> clockgen_irq || !irq_en_r || !auto_r || stop_all)
      else $error("irq dropped while flag and enable still set");
   chk_manual_no_flag: assert property (
      clk_en && !auto_r |=> !flag_r && !clockgen_irq)
      else $error("flag or irq seen in manual mode");
   chk_lock_sets_flag: assert property (
      clk_en && auto_r && lock_toggle |=> flag_r)
      else $error("lock change did not set flag");
   chk_read_clears_flag: assert property (
      clk_en && flag_clr && !lock_toggle && auto_r |=> !flag_r)
      else $error("read of loop control did not clear flag");
   chk_break_keeps_flag: assert property (
      clk_en && break_active && !break_clear_enable && flag_r && auto_r |=> flag_r)
      else $error("flag lost during protected break");
   chk_mul_locked: assert property (
      clk_en && pwr_on_r |=> $stable(mul_r))
      else $error("multiplier changed while loop on");
   chk_vrs_locked: assert property (
      clk_en && pwr_on_r |=> $stable(vrs_r))
      else $error("range changed while loop on");
   chk_src_guard: assert property (
      bcs_r |-> pwr_on_r && !vrs_zero ##1 pwr_on_r)
      else $error("source bit set without loop on");
   chk_zero_mul_one: assert property (
      mul_r == 12'h000 |-> feedback_divider == PBM_MUL_ONE)
      else $error("zero multiplier not treated as one");
   chk_stop_outputs: assert property (
      stop_mode && !osc_run_in_stop |-> !crystal_clock_en && !base_clock_out_en
         && !clockgen_irq && !loop_enable)
      else $error("outputs active in full stop");
   chk_acq_held_auto: assert property (
      clk_en && auto_r |=> $stable(acq_man_r))
      else $error("manual acquire value lost in auto mode");
   chk_wait_no_effect: assert property (
      wait_mode && !stop_mode |-> loop_enable == (pwr_on_r && !vrs_zero))
      else $error("wait state altered loop enable");

   cov_lock_irq: cover property (auto_r && irq_en_r && lock_toggle ##1 clockgen_irq);
   cov_flag_read: cover property (flag_r ##1 flag_clr ##1 !flag_r);
   cov_source_vco: cover property (!bcs_r ##1 bcs_r);
   cov_mul_write: cover property (!pwr_on_r && wr_en && aw_addr_r == PBM_OFS_MUL_LOW);
endmodule : pbm_ctrl

// file: logic/pbm_pkg.sv
// package: register map, field positions and reset values of the loop control block
package pbm_pkg;
   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] PBM_OFS_LOOP_CTRL = 8'h00; // loop_control_reg
   localparam logic [7:0] PBM_OFS_BW_CTRL = 8'h04; // bandwidth_control_reg
   localparam logic [7:0] PBM_OFS_MUL_HIGH = 8'h08; // feedback_multiplier_high
   localparam logic [7:0] PBM_OFS_MUL_LOW = 8'h0C; // feedback_multiplier_low
   localparam logic [7:0] PBM_OFS_VCO_RANGE = 8'h10; // vco_range_select
   localparam int PBM_ADDR_W = 8; // decoded address bits
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PBM_BIT_IRQ_EN = 7; // loop_change_irq_enable
   localparam int PBM_BIT_FLAG = 6; // loop_change_flag
   localparam int PBM_BIT_PWR_ON = 5; // loop_power_on
   localparam int PBM_BIT_BCS = 4; // base_clock_source
   localparam int PBM_BIT_VPR_HI = 1; // power-of-two range, top bit
   localparam int PBM_BIT_AUTO = 7; // automatic bandwidth control
   localparam int PBM_BIT_LOCK = 6; // lock indicator
   localparam int PBM_BIT_ACQ = 5; // acquire_track_bit
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [11:0] PBM_RST_MUL = 12'h040; // feedback multiply of 64
   localparam logic [7:0] PBM_RST_VRS = 8'h40; // range multiply of 64
   localparam logic PBM_RST_PWR_ON = 1'b1; // loop on out of reset
   localparam logic PBM_RST_ACQ = 1'b0; // acquisition mode
   localparam logic [11:0] PBM_MUL_ONE = 12'h001; // zero behaves as one
   // ---------------------------------------------------------------
   // bus responses
   // ---------------------------------------------------------------
   localparam logic [1:0] PBM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PBM_RESP_SLVERR = 2'h2;
endpackage : pbm_pkg

// file: test/pll_bandwidth_multiplier_control_test.sv
// testbench: register port, protection, flag and low-power behaviour of the loop control block
`timescale 1ns/100ps
module pll_bandwidth_multiplier_control_test;
   import pbm_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clock, arst_n, clk_en; // clock, reset, enable
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // write handshakes
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // response, read address
   logic s_axi_rvalid, s_axi_rready; // read data handshake
   logic [7:0] s_axi_awaddr, s_axi_araddr; // byte addresses
   logic [31:0] s_axi_wdata, s_axi_rdata; // data words
   logic [3:0] s_axi_wstrb; // byte lanes
   logic [1:0] s_axi_bresp, s_axi_rresp; // response codes
   logic loop_lock_in, loop_track_in, wait_mode, stop_mode; // loop and state inputs
   logic osc_run_in_stop, break_active, break_clear_enable; // option and break inputs
   logic osc_enable, loop_enable, vco_select, crystal_clock_en; // enables
   logic base_clock_out_en, clockgen_irq, force_track, bandwidth_auto; // status outputs
   logic [11:0] feedback_divider; // effective multiplier
   logic [7:0] vco_range_field; // range field
   logic [1:0] vco_power_range; // power-of-two range
   logic [31:0] rv; // last read word
   logic [7:0] h, l; // random multiplier bytes
   int error_cnt, checks; // counters

   pbm_ctrl i_dut (.*);

   // free-running clock, 4 ns period
   always #2 clock = ~clock;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // expected divider: zero behaves as one
   function automatic logic [11:0] exp_div(input logic [11:0] m);
      return (m == 12'h000) ? PBM_MUL_ONE : m;
   endfunction : exp_div

   // verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // compare with case equality so unknowns never match
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask : chk

   // a bus wait that ran out ends the run
   task automatic hang(input logic ok);
      if (!ok) begin
         error_cnt++;
         $display("unexpected at %0t: bus gave no answer", $time);
         complete_run();
      end
   endtask : hang

   // end-of-test line
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   // wait k edges, then stop at the falling edge where outputs are settled
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      @(negedge clock);
   endtask : cyc

   // write one register; readies are sampled where they stand before the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] e = PBM_RESP_OKAY);
      int n;
      logic aw, w, b;
      logic [1:0] r;
      @(posedge clock);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      n = 0;
      b = 1'b0;
      while (!b && n < 64) begin
         @(negedge clock);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         n++;
      end
      hang(b);
      chk(r, e);
   endtask : wr

   // read one register into rv
   task automatic rd(input logic [7:0] a, input logic [1:0] e = PBM_RESP_OKAY);
      int n;
      logic ar, v;
      logic [1:0] r;
      @(posedge clock);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      n = 0;
      v = 1'b0;
      while (!v && n < 64) begin
         @(negedge clock);
         ar = s_axi_arvalid & s_axi_arready;
         v = s_axi_rvalid;
         rv = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ar) s_axi_arvalid <= 1'b0;
         n++;
      end
      hang(v);
      chk(r, e);
   endtask : rd

   // read and compare the low byte, upper bits zero
   task automatic rc(input logic [7:0] a, input logic [7:0] x);
      rd(a);
      chk(rv, {24'h000000, x});
   endtask : rc

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {clock, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
      {loop_lock_in, loop_track_in, wait_mode, stop_mode} = 4'h0;
      {osc_run_in_stop, break_active, break_clear_enable} = 3'h0;
      {clk_en, s_axi_bready, s_axi_rready} = 3'h7;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      error_cnt = 0;
      checks = 0;
      void'($urandom(7535));
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      // reset values
      rc(PBM_OFS_LOOP_CTRL, 8'h20);
      rc(PBM_OFS_BW_CTRL, 8'h00);
      rc(PBM_OFS_MUL_HIGH, 8'h00);
      rc(PBM_OFS_MUL_LOW, 8'h40);
      rc(PBM_OFS_VCO_RANGE, 8'h40);
      chk({force_track, feedback_divider}, {1'b0, PBM_RST_MUL});
      done("reset");
      // programming refused while the loop is on
      wr(PBM_OFS_MUL_LOW, 8'h12);
      wr(PBM_OFS_MUL_HIGH, 8'h05);
      wr(PBM_OFS_VCO_RANGE, 8'h00);
      rc(PBM_OFS_MUL_LOW, 8'h40);
      rc(PBM_OFS_MUL_HIGH, 8'h00);
      rc(PBM_OFS_VCO_RANGE, 8'h40);
      done("protect");
      // power-on and source bit guard each other
      wr(PBM_OFS_LOOP_CTRL, 8'h30);
      cyc(1);
      chk(vco_select, 1'b1);
      wr(PBM_OFS_LOOP_CTRL, 8'h10);
      rc(PBM_OFS_LOOP_CTRL, 8'h30);
      wr(PBM_OFS_LOOP_CTRL, 8'h00);
      wr(PBM_OFS_LOOP_CTRL, 8'h00);
      wr(PBM_OFS_LOOP_CTRL, 8'h12);
      rc(PBM_OFS_LOOP_CTRL, 8'h02);
      chk({vco_select, vco_power_range}, 3'b010);
      done("source");
      // multiplier with the loop off: zero corner then random values
      wr(PBM_OFS_MUL_HIGH, 8'hFF);
      rc(PBM_OFS_MUL_HIGH, 8'h0F);
      for (int i = 0; i < 6; i++) begin
         h = (i == 0) ? 8'h00 : 8'($urandom);
         l = (i == 0) ? 8'h00 : 8'($urandom);
         wr(PBM_OFS_MUL_HIGH, h);
         wr(PBM_OFS_MUL_LOW, l);
         cyc(1);
         chk(feedback_divider, exp_div({h[3:0], l}));
         rc(PBM_OFS_MUL_LOW, l);
      end
      // a write without the low byte lane leaves the register alone
      s_axi_wstrb <= 4'hE;
      wr(PBM_OFS_MUL_LOW, ~l);
      s_axi_wstrb <= 4'hF;
      rc(PBM_OFS_MUL_LOW, l);
      wr(8'h14, 8'h55, PBM_RESP_SLVERR);
      rd(8'h14, PBM_RESP_SLVERR);
      chk(rv, 32'h00000000);
      done("multiplier");
      // zero range keeps the loop off and blocks the source bit
      wr(PBM_OFS_VCO_RANGE, 8'h00);
      wr(PBM_OFS_LOOP_CTRL, 8'h20);
      wr(PBM_OFS_LOOP_CTRL, 8'h30);
      cyc(1);
      chk({loop_enable, vco_select, vco_range_field}, 10'h000);
      rc(PBM_OFS_LOOP_CTRL, 8'h20);
      wr(PBM_OFS_LOOP_CTRL, 8'h00);
      wr(PBM_OFS_VCO_RANGE, 8'h40);
      wr(PBM_OFS_LOOP_CTRL, 8'h20);
      cyc(1);
      chk(loop_enable, 1'b1);
      done("range");
      // acquire/track bit in manual and automatic control
      wr(PBM_OFS_BW_CTRL, 8'h20);
      @(posedge clock) loop_lock_in <= 1'b1;
      rc(PBM_OFS_BW_CTRL, 8'h20);
      chk({bandwidth_auto, force_track}, 2'b01);
      wr(PBM_OFS_BW_CTRL, 8'hA0);
      wr(PBM_OFS_BW_CTRL, 8'h80);
      rc(PBM_OFS_BW_CTRL, 8'hC0);
      chk({bandwidth_auto, force_track}, 2'b11);
      @(posedge clock) loop_track_in <= 1'b1;
      rc(PBM_OFS_BW_CTRL, 8'hE0);
      wr(PBM_OFS_BW_CTRL, 8'h00);
      rc(PBM_OFS_BW_CTRL, 8'h20);
      chk(force_track, 1'b1);
      done("bandwidth");
      // lock change flag, request line and read clear
      wr(PBM_OFS_BW_CTRL, 8'hA0);
      wr(PBM_OFS_LOOP_CTRL, 8'hA0);
      rc(PBM_OFS_LOOP_CTRL, 8'hA0);
      @(posedge clock) loop_lock_in <= 1'b0;
      cyc(3);
      chk(clockgen_irq, 1'b1);
      cyc(6);
      chk(clockgen_irq, 1'b1);
      rc(PBM_OFS_BW_CTRL, 8'hA0);
      rc(PBM_OFS_LOOP_CTRL, 8'hE0);
      cyc(0);
      chk(clockgen_irq, 1'b0);
      rc(PBM_OFS_LOOP_CTRL, 8'hA0);
      wr(PBM_OFS_LOOP_CTRL, 8'h20);
      @(posedge clock) loop_lock_in <= 1'b1;
      cyc(3);
      chk(clockgen_irq, 1'b0);
      rc(PBM_OFS_LOOP_CTRL, 8'h60);
      done("flag");
      // debug break with and without clearing allowed
      break_active <= 1'b1;
      @(posedge clock) loop_lock_in <= 1'b0;
      cyc(3);
      rc(PBM_OFS_LOOP_CTRL, 8'h60);
      rc(PBM_OFS_LOOP_CTRL, 8'h60);
      break_clear_enable <= 1'b1;
      rc(PBM_OFS_LOOP_CTRL, 8'h60);
      rc(PBM_OFS_LOOP_CTRL, 8'h20);
      break_active <= 1'b0;
      rc(PBM_OFS_LOOP_CTRL, 8'h20);
      done("break");
      // wait leaves everything running, stop shuts down
      wr(PBM_OFS_LOOP_CTRL, 8'hA0);
      @(posedge clock) loop_lock_in <= 1'b1;
      wait_mode <= 1'b1;
      cyc(3);
      chk({clockgen_irq, loop_enable, osc_enable, base_clock_out_en}, 4'hF);
      // source bit selected with the loop on and the range nonzero, lock not required
      rc(PBM_OFS_BW_CTRL, 8'hE0);
      wr(PBM_OFS_LOOP_CTRL, 8'hB0);
      chk(vco_select, 1'b1);
      @(posedge clock) stop_mode <= 1'b1;
      cyc(2);
      chk({osc_enable, crystal_clock_en, base_clock_out_en, clockgen_irq}, 4'h0);
      @(posedge clock) osc_run_in_stop <= 1'b1;
      cyc(2);
      chk({osc_enable, crystal_clock_en, loop_enable}, 3'b110);
      @(posedge clock) stop_mode <= 1'b0;
      wait_mode <= 1'b0;
      rc(PBM_OFS_LOOP_CTRL, 8'hF0);
      done("power");
      // manual control silences the flag and the request
      wr(PBM_OFS_BW_CTRL, 8'h00);
      @(posedge clock) loop_lock_in <= 1'b0;
      cyc(3);
      chk(clockgen_irq, 1'b0);
      rc(PBM_OFS_LOOP_CTRL, 8'h30);
      done("manual");
      complete_run();
   end
endmodule : pll_bandwidth_multiplier_control_test
